//--- hdl/hall_sync_pkg.sv
/*
  constants for the hall-synchronised sine pwm generator.
  assumes a 100 mhz system clock.
*/
package hall_sync_pkg;
  // ----------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_MS;
  localparam int RES_US = 16;
  localparam int RES_CYCLES = CLK_FREQ_HZ / 1000000 * RES_US;
  localparam int WDOG_MS = 127;
  // ----------------------------------------------------------
  // pwm, table and phase
  // ----------------------------------------------------------
  localparam int PWM_BITS = 12;
  localparam logic [11:0] PWM_RELOAD_DEF = 12'h000;
  localparam int LUT_DEPTH = 256;
  localparam int LUT_BITS = 8;
  localparam logic [7:0] PHI_DEF = 8'h00;
  localparam logic [7:0] PHASE_PI = 8'h80;
  localparam logic [7:0] PHASE_120 = 8'h55;
  localparam logic [7:0] PHASE_240 = 8'hab;
  localparam logic [17:0] FREQ_NUM = 18'h3ffff;
endpackage : hall_sync_pkg

//--- hdl/hall_sync_sine_pwm.sv
/*
  hall-synchronised three-phase sine pwm generator.
  assumes one hall pin (asynchronous) and an external bridge with dead time.
*/
`timescale 1ns/1ps

module hall_sync_sine_pwm
  import hall_sync_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES,
  parameter int RES_CNT = RES_CYCLES,
  parameter int WDOG_TICKS = WDOG_MS / TICK_MS
) (
  // system
  input wire logic clk,
  input wire logic rst,
  // hall sensor pin
  input wire logic hall_in,
  // control
  input wire logic [11:0] pwm_reload,
  input wire logic [7:0] phi,
  input wire logic [7:0] phase_step,
  // pwm outputs
  output logic phase_a_pwm_output,
  output logic phase_b_pwm_output,
  output logic phase_c_pwm_output,
  // measurement and events
  output logic capture_event,
  output logic [15:0] semi_period,
  output logic [15:0] elec_freq,
  output logic [15:0] millisecond_time_base,
  output logic pwm_overflow_event,
  output logic wdog_reset
);
  // ----------------------------------------------------------
  // hall synchroniser and edge
  // ----------------------------------------------------------
  logic hall_s1_reg, hall_s2_reg, hall_s3_reg;
  always_ff @(posedge clk) begin
    hall_s1_reg <= hall_in;
    hall_s2_reg <= hall_s1_reg;
    hall_s3_reg <= hall_s2_reg;
  end
  wire hall_edge = hall_s2_reg ^ hall_s3_reg;

  // ----------------------------------------------------------
  // timebases
  // ----------------------------------------------------------
  logic [31:0] tick_cnt_reg, res_cnt_reg;
  logic [15:0] ms_cnt_reg, res_period_reg;
  wire tick = (tick_cnt_reg == 32'(TICK_CNT - 1));
  wire res_tick = (res_cnt_reg == 32'(RES_CNT - 1));
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      res_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
      res_cnt_reg <= (res_tick || hall_edge) ? '0 : res_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ms_cnt_reg <= '0;
      millisecond_time_base <= '0;
    end else begin
      // saturates so a long stall keeps the watchdog expired
      if (hall_edge) ms_cnt_reg <= '0;
      else if (tick && ms_cnt_reg != 16'hffff) ms_cnt_reg <= ms_cnt_reg + 16'h1;
      if (tick) millisecond_time_base <= millisecond_time_base + 16'h1;
    end
  end

  // ----------------------------------------------------------
  // capture, sync, watchdog
  // ----------------------------------------------------------
  logic [7:0] phase_reg;
  logic wdog_en_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      res_period_reg <= '0;
      semi_period <= '0;
      capture_event <= 1'b0;
    end else begin
      capture_event <= hall_edge;
      if (hall_edge) begin
        semi_period <= res_period_reg;
        res_period_reg <= '0;
      end else if (res_tick && res_period_reg != 16'hffff) begin
        res_period_reg <= res_period_reg + 16'h1;
      end
    end
  end

  // watchdog enable and refresh
  // the ms semi-period count doubles as the refresh counter
  always_ff @(posedge clk) begin
    if (rst) begin
      wdog_en_reg <= 1'b0;
      wdog_reset <= 1'b0;
    end else begin
      if (hall_edge) wdog_en_reg <= 1'b1;
      wdog_reset <= wdog_en_reg && !hall_edge && (ms_cnt_reg >= 16'(WDOG_TICKS));
    end
  end

  // ----------------------------------------------------------
  // frequency divider, sequential restoring division
  // ----------------------------------------------------------
  logic [17:0] rem_reg;
  logic [17:0] quo_reg;
  logic [15:0] div_reg;
  logic [4:0] div_cnt_reg;
  wire [18:0] trial = {rem_reg, FREQ_NUM[5'd17 - div_cnt_reg]} - {3'h0, div_reg};
  always_ff @(posedge clk) begin
    if (rst) begin
      rem_reg <= '0;
      quo_reg <= '0;
      div_reg <= '0;
      div_cnt_reg <= 5'd18;
      elec_freq <= '0;
    end else if (capture_event) begin
      div_reg <= semi_period;
      rem_reg <= '0;
      // zero period skips the final latch so the saturated value stays
      div_cnt_reg <= (semi_period == 16'h0) ? 5'd19 : 5'd0;
      if (semi_period == 16'h0) elec_freq <= 16'hffff;
    end else if (div_cnt_reg < 5'd18) begin
      if (!trial[18]) begin
        rem_reg <= trial[17:0];
        quo_reg <= {quo_reg[16:0], 1'b1};
      end else begin
        rem_reg <= {rem_reg[16:0], FREQ_NUM[5'd17 - div_cnt_reg]};
        quo_reg <= {quo_reg[16:0], 1'b0};
      end
      div_cnt_reg <= div_cnt_reg + 5'd1;
    end else if (div_cnt_reg == 5'd18) begin
      elec_freq <= (quo_reg[17:16] != 2'b0) ? 16'hffff : quo_reg[15:0];
      div_cnt_reg <= 5'd19;
    end
  end

  // ----------------------------------------------------------
  // pwm carrier and sine update
  // ----------------------------------------------------------
  logic [11:0] pwm_cnt_reg;
  logic half_reg;
  wire ovf = (pwm_cnt_reg >= pwm_reload);
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_cnt_reg <= '0;
      pwm_overflow_event <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      pwm_cnt_reg <= ovf ? '0 : pwm_cnt_reg + 12'h1;
      pwm_overflow_event <= ovf;
      if (ovf) half_reg <= ~half_reg;
    end
  end
  wire upd = ovf && half_reg;

  // force angle from sampled hall level
  always_ff @(posedge clk) begin
    if (rst) phase_reg <= PHI_DEF;
    else if (hall_edge) phase_reg <= hall_s2_reg ? phi : 8'(phi + PHASE_PI);
    else if (upd) phase_reg <= 8'(phase_reg + phase_step);
  end

  wire [7:0] lut_c, lut_a, lut_b;
  wire [7:0] idx_a = 8'(phase_reg + PHASE_120);
  wire [7:0] idx_b = 8'(phase_reg + PHASE_240);
  sine_lut u_lut_c (.idx(phase_reg), .duty(lut_c));
  sine_lut u_lut_a (.idx(idx_a), .duty(lut_a));
  sine_lut u_lut_b (.idx(idx_b), .duty(lut_b));

  logic [7:0] duty_a_reg, duty_b_reg, duty_c_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      duty_a_reg <= 8'h80;
      duty_b_reg <= 8'h80;
      duty_c_reg <= 8'h80;
    end else if (upd) begin
      duty_a_reg <= lut_a;
      duty_b_reg <= lut_b;
      duty_c_reg <= lut_c;
    end
  end

  // duty scaled to reload: compare against top 8 bits of normalised count
  function automatic logic cmp(input logic [11:0] cnt, input logic [11:0] rl,
                               input logic [7:0] d);
    logic [19:0] lim;
    lim = 20'(rl) * 20'(d);
    return {cnt, 8'h00} < lim;
  endfunction : cmp

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_a_pwm_output <= 1'b0;
      phase_b_pwm_output <= 1'b0;
      phase_c_pwm_output <= 1'b0;
    end else begin
      phase_a_pwm_output <= cmp(pwm_cnt_reg, pwm_reload, duty_a_reg);
      phase_b_pwm_output <= cmp(pwm_cnt_reg, pwm_reload, duty_b_reg);
      phase_c_pwm_output <= cmp(pwm_cnt_reg, pwm_reload, duty_c_reg);
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  a_capture_pulse: assert property (@(posedge clk) disable iff (rst)
    hall_edge |=> capture_event && semi_period == $past(res_period_reg))
    else $error("capture missing");
  a_phase_force: assert property (@(posedge clk) disable iff (rst)
    hall_edge && !hall_s2_reg |=> phase_reg == 8'($past(phi) + PHASE_PI))
    else $error("phase not forced");
  a_phase_level: assert property (@(posedge clk) disable iff (rst)
    hall_edge && hall_s2_reg |=> phase_reg == $past(phi))
    else $error("phase level wrong");
  a_wdog_quiet: assert property (@(posedge clk) disable iff (rst)
    hall_edge |=> !wdog_reset)
    else $error("watchdog after edge");
  a_update_rate: assert property (@(posedge clk) disable iff (rst)
    ovf && !half_reg |=> $stable(duty_c_reg))
    else $error("duty updated early");
  a_overflow_wrap: assert property (@(posedge clk) disable iff (rst)
    ovf |=> pwm_cnt_reg == 12'h0 && pwm_overflow_event)
    else $error("no reload");
  a_ms_tick: assert property (@(posedge clk) disable iff (rst)
    tick |=> millisecond_time_base == 16'($past(millisecond_time_base) + 16'h1))
    else $error("time base stuck");
  a_lut_offset: assert property (@(posedge clk) disable iff (rst)
    upd |=> duty_c_reg == $past(lut_c) && duty_a_reg == $past(lut_a))
    else $error("duty not from table");
  a_freq_done: assert property (@(posedge clk) disable iff (rst)
    capture_event && semi_period != 16'h0 |-> ##[1:21] div_cnt_reg == 5'd19)
    else $error("divide slow");
endmodule : hall_sync_sine_pwm

//--- hdl/sine_lut.sv
/*
  256 x 8 sine table, offset binary (mid 0x80).
  assumes the caller registers the output.
*/
`timescale 1ns/1ps
module sine_lut
  import hall_sync_pkg::*;
(
  // lookup
  input wire logic [7:0] idx,
  output logic [7:0] duty
);
  // ----------------------------------------------------------
  // table contents
  // ----------------------------------------------------------
  // quarter-wave symmetry keeps the constant table at 64 entries
  function automatic logic [7:0] quarter(input logic [5:0] i);
    logic [7:0] q [0:63];
    q = '{8'h00,8'h03,8'h06,8'h09,8'h0c,8'h10,8'h13,8'h16,8'h19,8'h1c,8'h1f,8'h22,
          8'h25,8'h28,8'h2b,8'h2e,8'h31,8'h33,8'h36,8'h39,8'h3c,8'h3f,8'h41,8'h44,
          8'h47,8'h49,8'h4c,8'h4e,8'h51,8'h53,8'h55,8'h58,8'h5a,8'h5c,8'h5e,8'h60,
          8'h62,8'h64,8'h66,8'h68,8'h6a,8'h6b,8'h6d,8'h6f,8'h70,8'h71,8'h73,8'h74,
          8'h75,8'h76,8'h78,8'h79,8'h7a,8'h7a,8'h7b,8'h7c,8'h7d,8'h7d,8'h7e,8'h7e,
          8'h7e,8'h7f,8'h7f,8'h7f};
    return q[i];
  endfunction : quarter

  wire [5:0] qidx = idx[6] ? ~idx[5:0] : idx[5:0];
  wire [7:0] mag = quarter(qidx);
  assign duty = idx[7] ? 8'(8'h80 - mag) : 8'(8'h80 + mag);
endmodule : sine_lut

//--- tb/hall_bridge_model.sv
/*
  hall sensor and inverter bridge model for the sine pwm generator.
  assumes spin, half_cycles and meas change just after rising edges.
*/
`timescale 1ns/1ps
module hall_bridge_model (
  // system
  input wire logic clk,
  // hall sensor
  input wire logic spin,
  input wire logic [15:0] half_cycles,
  output logic hall_in,
  // bridge legs
  input wire logic leg_a,
  input wire logic leg_b,
  input wire logic leg_c,
  input wire logic meas,
  output logic [15:0] on_a,
  output logic [15:0] on_b,
  output logic [15:0] on_c
);
  logic [15:0] gap_reg = 16'h0000;
  logic hall_reg = 1'b0;
  assign hall_in = hall_reg;
  // ----------------------------------------
  // sensor: level holds while the rotor stands
  // ----------------------------------------
  always @(posedge clk) begin
    gap_reg <= spin ? gap_reg + 16'h0001 : 16'h0000;
    if (spin && gap_reg >= half_cycles - 16'h0001) begin
      gap_reg <= 16'h0000;
      hall_reg <= ~hall_reg;
    end
  end
  // ----------------------------------------
  // bridge: on-time of each leg in the window
  // ----------------------------------------
  always @(posedge clk) begin
    on_a <= meas ? on_a + 16'(leg_a) : 16'h0000;
    on_b <= meas ? on_b + 16'(leg_b) : 16'h0000;
    on_c <= meas ? on_c + 16'(leg_c) : 16'h0000;
  end
endmodule : hall_bridge_model

//--- tb/hall_sync_sine_pwm_test.sv
/*
  self-checking bench for the hall-synchronised sine pwm generator.
  assumes short tick, resolution and watchdog counts set below.
*/
`timescale 1ns/1ps
module hall_sync_sine_pwm_test;
  import hall_sync_pkg::*;
  logic clk, rst, spin, meas, hall_in, pa, pb, pc, cap, ovf, wdog;
  logic [15:0] half_cycles, on_a, on_b, on_c, sp, semi_period, elec_freq, ms_base;
  logic [11:0] pwm_reload;
  logic [7:0] phi, phase_step;
  int err_count, total_checks, n;
  hall_sync_sine_pwm #(.TICK_CNT(10), .RES_CNT(4), .WDOG_TICKS(3)) DUT (
    .clk(clk), .rst(rst), .hall_in(hall_in), .pwm_reload(pwm_reload), .phi(phi),
    .phase_step(phase_step), .phase_a_pwm_output(pa), .phase_b_pwm_output(pb),
    .phase_c_pwm_output(pc), .capture_event(cap), .semi_period(semi_period),
    .elec_freq(elec_freq), .millisecond_time_base(ms_base), .pwm_overflow_event(ovf),
    .wdog_reset(wdog));
  hall_bridge_model partner (.clk(clk), .spin(spin), .half_cycles(half_cycles),
    .hall_in(hall_in), .leg_a(pa), .leg_b(pb), .leg_c(pc), .meas(meas),
    .on_a(on_a), .on_b(on_b), .on_c(on_c));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic wait_ev(input logic sel, input int lim);
    n = 0;
    while ((sel ? ovf : cap) !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    check("event wait", 16'(n < lim), 16'h0001);
  endtask : wait_ev
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_wdog;
    step(100);
    check("wdog unarmed", 16'(wdog), 16'h0000);
    @(posedge clk) spin <= 1'b1;
    step(200);
    check("wdog refreshed", 16'(wdog), 16'h0000);
    @(posedge clk) spin <= 1'b0;
    n = 0;
    while (wdog !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    check("wdog expiry", 16'(n < 50), 16'h0001);
  endtask : t_wdog
  task automatic t_carrier;
    wait_ev(1'b1, 100);
    n = 0;
    do begin
      step(1);
      n++;
    end while (ovf !== 1'b1 && n < 40);
    check("carrier period", 16'(n), 16'd16);
    sp = ms_base;
    step(50);
    check("ms base", ms_base - sp, 16'd5);
  endtask : t_carrier
  task automatic t_period;
    @(posedge clk) half_cycles <= 16'd400;
    spin <= 1'b1;
    wait_ev(1'b0, 600);
    step(1);
    check("capture pulse", 16'(cap), 16'h0000);
    wait_ev(1'b0, 600);
    sp = semi_period;
    check("semi period", 16'(sp >= 16'd99 && sp <= 16'd101), 16'h0001);
    step(25);
    check("frequency", elec_freq, 16'(FREQ_NUM / 18'(sp)));
  endtask : t_period
  task automatic t_phase;
    logic [15:0] lo;
    @(posedge clk) pwm_reload <= 12'h0ff;
    repeat (2) begin
      wait_ev(1'b0, 900);
      @(posedge clk) spin <= 1'b0;
      step(1100);
      @(posedge clk) meas <= 1'b1;
      repeat (512) @(posedge clk);
      meas <= 1'b0;
      #1;
      lo = hall_in ? 16'd64 : 16'd320;
      check("phase c", 16'(hall_in ? on_c > 400 : on_c < 112), 16'h0001);
      check("phase a", 16'(on_a > lo && on_a < lo + 16'd128), 16'h0001);
      check("phase b", 16'(on_b > lo && on_b < lo + 16'd128), 16'h0001);
      @(posedge clk) spin <= 1'b1;
    end
  endtask : t_phase
  // stepping by pi flips phase c between peak and trough at each update
  task automatic t_advance;
    int hi, prev, flips;
    @(posedge clk) spin <= 1'b0;
    pwm_reload <= 12'h00f;
    phase_step <= PHASE_PI;
    step(40);
    wait_ev(1'b1, 100);
    prev = 0;
    flips = 0;
    for (int p = 0; p < 8; p++) begin
      hi = 0;
      repeat (16) begin
        hi += int'(pc);
        step(1);
      end
      if (p > 0 && (hi > 8) != (prev > 8)) flips++;
      prev = hi;
    end
    check("update cadence", 16'(flips >= 3 && flips <= 4), 16'h0001);
  endtask : t_advance
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {spin, meas, err_count, total_checks} = '0;
    half_cycles = 16'd20;
    pwm_reload = 12'h00f;
    phi = 8'h40;
    phase_step = 8'h00;
    step(2);
    check("reset outputs", 16'({cap, ovf, wdog}), 16'h0000);
    @(posedge clk) rst <= 1'b0;
    t_wdog();
    t_carrier();
    t_period();
    t_phase();
    t_advance();
    tally_and_finish();
  end
  initial begin
    repeat (12000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule : hall_sync_sine_pwm_test
